// ### rtl/srq_cfg.svh
// constants of the status reporting and error queue block
`ifndef SRQ_CFG_SVH
`define SRQ_CFG_SVH

// register width and implemented bits
`define SRQ_REG_W 16
`define SRQ_OPER_IMPL 16'h0521
`define SRQ_QUES_IMPL 16'h0008
`define SRQ_MASK_RST 16'h0000
`define SRQ_EVENT_RST 16'h0000

// operation bit positions
`define SRQ_OPER_CAL_BIT 0
`define SRQ_OPER_WTG_BIT 5
`define SRQ_OPER_CV_BIT 8
`define SRQ_OPER_CC_BIT 10

// questionable bit positions
`define SRQ_QUES_OT_BIT 3

// status byte summary bit positions
`define SRQ_STB_QUES_BIT 3
`define SRQ_STB_OPER_BIT 7
`define SRQ_STB_RST 8'h00

// error queue: depth, code width, fixed codes (two's complement)
`define SRQ_ERR_DEPTH 15
`define SRQ_ERR_W 16
`define SRQ_ERR_NONE 16'h0000
`define SRQ_ERR_TOO_MANY 16'hfea2

`endif

// ### rtl/srq_pkg.sv
// types shared by the status reporting and error queue block
package srq_pkg;

  // host commands and queries, as decoded by the parser outside
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_OPER_ENAB_WR = 4'h1,
    OP_OPER_ENAB_RD = 4'h2,
    OP_OPER_EVEN_RD = 4'h3,
    OP_OPER_COND_RD = 4'h4,
    OP_QUES_ENAB_WR = 4'h5,
    OP_QUES_ENAB_RD = 4'h6,
    OP_QUES_EVEN_RD = 4'h7,
    OP_QUES_COND_RD = 4'h8,
    OP_PRESET = 4'h9,
    OP_ERR_RD = 4'ha,
    OP_ERR_CODE_RD = 4'hb,
    OP_ERR_ALL_RD = 4'hc
  } srq_op_type;

  // one command from the parser
  typedef struct packed {
    logic valid;
    srq_op_type op;
    logic [15:0] data;
  } srq_cmd_type;

  // one answer word to the parser
  typedef struct packed {
    logic valid;
    logic last;
    logic with_text;
    logic [15:0] data;
  } srq_rsp_type;

  // answer sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LIST = 2'b10
  } srq_state_type;

endpackage

// ### rtl/srq_err_fifo.sv
// error queue: first in first out, overflow marks the newest entry
`timescale 1ns/10ps
module srq_err_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 15,
  parameter int PW = $clog2(DEPTH),
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic [W-1:0] over_data,
  input wire logic pop,
  input wire logic [CW-1:0] peek_idx,
  output logic [W-1:0] head_data,
  output logic [W-1:0] peek_data,
  output logic [CW-1:0] count,
  output logic empty
);

  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW:0] DEPTH_W = (CW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] rd_q;
  logic [PW-1:0] wr_q;
  logic [CW-1:0] cnt_q;
  logic pop_ok;
  logic room;
  logic push_ok;
  logic push_over;
  logic [PW-1:0] wr_prev;
  logic [CW:0] peek_sum;
  logic [PW-1:0] peek_ptr;

  // pointer step with wrap at the odd depth
  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // a pop in the same cycle frees a slot for the push
  assign pop_ok = pop & (cnt_q != '0);
  assign room = (cnt_q != CW'(DEPTH)) | pop_ok;
  assign push_ok = push & room;
  assign push_over = push & ~room;
  assign wr_prev = (wr_q == '0) ? LAST : wr_q - 1'b1;
  assign peek_sum = (CW+1)'(rd_q) + {1'b0, peek_idx};
  assign peek_ptr = (peek_sum >= DEPTH_W) ?
    PW'(peek_sum - DEPTH_W) : PW'(peek_sum);

  // storage: oldest entries kept, newest overwritten by the marker
  always_ff @(posedge sys_clk) begin
    if (push_ok) begin
      mem[wr_q] <= push_data;
    end else if (push_over) begin
      mem[wr_prev] <= over_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (pop_ok) rd_q <= inc(rd_q);
      if (push_ok) wr_q <= inc(wr_q);
      cnt_q <= cnt_q + CW'(push_ok) - CW'(pop_ok);
    end
  end

  assign head_data = mem[rd_q];
  assign peek_data = mem[peek_ptr];
  assign count = cnt_q;
  assign empty = (cnt_q == '0);

endmodule // srq_err_fifo

// ### rtl/srq_top.sv
// status reporting registers and error queue of the dc source
`timescale 1ns/10ps
`include "srq_cfg.svh"

// How it works
// - operation enable query returns the stored mask, only bits 0,5,8,10.
// - operation events latch each rising condition edge until the register is read.
// - reading operation events returns them, then clears all bits except those rising in the same cycle.
// - preset forces both enable masks to zero, reporting stops.
// - questionable events latch every event since the previous read.
// - reading questionable events returns them, then clears them.
// - questionable bit 3 is overtemperature; other bits read zero.
// - questionable condition shows the live unlatched state.
// - questionable enable write loads the mask gating the summary.
// - status byte bit 3 is OR of enabled questionable events.
// - questionable enable query returns the stored mask, only bit 3.
// - errors queue first in first out; each error or code-only query pops the oldest.
// - empty queue answers code zero; only the error query adds the no-error text.
// - queue holds 15; on overflow newest errors are dropped.
// - after overflow the last entry is too-many-errors, -350.
// - code-only query returns the next code without text.
// - all-codes query lists every queued code, or zero when empty.
// - operation bits: 0 calibration, 5 trigger wait, 8 voltage, 10 current.
// - status byte bit 7 is OR of enabled operation events.
module srq_top #(
  parameter int ERR_DEPTH = `SRQ_ERR_DEPTH,
  parameter int ERR_W = `SRQ_ERR_W,
  parameter int CW = $clog2(ERR_DEPTH + 1)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire srq_pkg::srq_cmd_type cmd,
  output logic cmd_ready,
  input wire logic cal_busy_flag,
  input wire logic trigger_wait_flag,
  input wire logic voltage_regulation_mode_flag,
  input wire logic current_limit_mode_flag,
  input wire logic over_temperature_flag,
  input wire logic err_push,
  input wire logic [ERR_W-1:0] err_code,
  output srq_pkg::srq_rsp_type rsp,
  output logic [7:0] status_byte,
  output logic [CW-1:0] err_count
);

  localparam logic [15:0] OPER_IMPL = `SRQ_OPER_IMPL;
  localparam logic [15:0] QUES_IMPL = `SRQ_QUES_IMPL;

  // registers
  logic [15:0] oper_prev_q;
  logic [15:0] ques_prev_q;
  logic [15:0] oper_cond_q;
  logic [15:0] oper_cond_d;
  logic [15:0] ques_cond_q;
  logic [15:0] ques_cond_d;
  logic [15:0] oper_ev_q;
  logic [15:0] oper_ev_d;
  logic [15:0] ques_ev_q;
  logic [15:0] ques_ev_d;
  logic [15:0] oper_en_q;
  logic [15:0] oper_en_d;
  logic [15:0] ques_en_q;
  logic [15:0] ques_en_d;
  logic [7:0] stb_q;
  logic [7:0] stb_d;
  srq_pkg::srq_state_type st_q;
  srq_pkg::srq_state_type st_d;
  logic [CW-1:0] idx_q;
  logic [CW-1:0] idx_d;
  logic [CW-1:0] num_q;
  logic [CW-1:0] num_d;
  srq_pkg::srq_rsp_type rsp_q;
  srq_pkg::srq_rsp_type rsp_d;
  logic ready_q;
  logic [CW-1:0] cnt_q;

  // decode wires
  logic [15:0] oper_live;
  logic [15:0] ques_live;
  logic [15:0] oper_rise;
  logic [15:0] ques_rise;
  logic take;
  logic is_preset;
  logic oper_ev_clr;
  logic ques_ev_clr;
  logic oper_en_wr;
  logic ques_en_wr;
  logic err_pop_req;
  logic err_pop;
  logic all_req;
  logic [ERR_W-1:0] head_code;
  logic [ERR_W-1:0] peek_code;
  logic [CW-1:0] q_count;
  logic q_empty;
  logic list_last;

  // live condition vectors; unused bits tied low
  always_comb begin
    oper_live = '0;
    oper_live[`SRQ_OPER_CAL_BIT] = cal_busy_flag;
    oper_live[`SRQ_OPER_WTG_BIT] = trigger_wait_flag;
    oper_live[`SRQ_OPER_CV_BIT] = voltage_regulation_mode_flag;
    oper_live[`SRQ_OPER_CC_BIT] = current_limit_mode_flag;
    ques_live = '0;
    ques_live[`SRQ_QUES_OT_BIT] = over_temperature_flag;
  end

  // command decode; a command is taken only while idle
  assign take = cmd.valid & ready_q;
  assign is_preset = take & (cmd.op == srq_pkg::OP_PRESET);
  assign oper_ev_clr = take & (cmd.op == srq_pkg::OP_OPER_EVEN_RD);
  assign ques_ev_clr = take & (cmd.op == srq_pkg::OP_QUES_EVEN_RD);
  assign oper_en_wr = take & (cmd.op == srq_pkg::OP_OPER_ENAB_WR);
  assign ques_en_wr = take & (cmd.op == srq_pkg::OP_QUES_ENAB_WR);
  assign err_pop_req = take & ((cmd.op == srq_pkg::OP_ERR_RD) |
                               (cmd.op == srq_pkg::OP_ERR_CODE_RD));
  assign err_pop = err_pop_req & ~q_empty;
  assign all_req = take & (cmd.op == srq_pkg::OP_ERR_ALL_RD);
  assign list_last = (idx_q == num_q - 1'b1);

  // edges against the raw previous sample, so preset makes no false edge
  assign oper_rise = oper_live & ~oper_prev_q;
  assign ques_rise = ques_live & ~ques_prev_q;

  // condition registers follow the live state; preset forces zero
  assign oper_cond_d = is_preset ? '0 : oper_live;
  assign ques_cond_d = is_preset ? '0 : ques_live;

  // event latches: the set wins over a same-cycle clearing read
  assign oper_ev_d = ((oper_ev_clr ? '0 : oper_ev_q) | oper_rise)
    & OPER_IMPL;
  assign ques_ev_d = ((ques_ev_clr ? '0 : ques_ev_q) | ques_rise)
    & QUES_IMPL;

  // enable masks keep only implemented bits; preset disables reporting
  assign oper_en_d = is_preset ? `SRQ_MASK_RST :
    oper_en_wr ? (cmd.data & OPER_IMPL) : oper_en_q;
  assign ques_en_d = is_preset ? `SRQ_MASK_RST :
    ques_en_wr ? (cmd.data & QUES_IMPL) : ques_en_q;

  // status byte summary bits from enabled latched events
  always_comb begin
    stb_d = `SRQ_STB_RST;
    stb_d[`SRQ_STB_QUES_BIT] = |(ques_ev_d & ques_en_d);
    stb_d[`SRQ_STB_OPER_BIT] = |(oper_ev_d & oper_en_d);
  end

  // answer sequencer: single answers, or a list of all queued codes
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    num_d = num_q;
    rsp_d = '0;
    case (st_q)
      srq_pkg::ST_IDLE: begin
        if (take) begin
          rsp_d.valid = 1'b1;
          rsp_d.last = 1'b1;
          case (cmd.op)
            srq_pkg::OP_OPER_ENAB_RD: rsp_d.data = oper_en_q;
            srq_pkg::OP_OPER_EVEN_RD: rsp_d.data = oper_ev_q;
            srq_pkg::OP_OPER_COND_RD: rsp_d.data = oper_cond_q;
            srq_pkg::OP_QUES_ENAB_RD: rsp_d.data = ques_en_q;
            srq_pkg::OP_QUES_EVEN_RD: rsp_d.data = ques_ev_q;
            srq_pkg::OP_QUES_COND_RD: rsp_d.data = ques_cond_q;
            srq_pkg::OP_ERR_RD: begin
              rsp_d.with_text = 1'b1;
              rsp_d.data = q_empty ? `SRQ_ERR_NONE : head_code;
            end
            srq_pkg::OP_ERR_CODE_RD: begin
              rsp_d.data = q_empty ? `SRQ_ERR_NONE : head_code;
            end
            srq_pkg::OP_ERR_ALL_RD: begin
              if (q_empty) begin
                rsp_d.data = `SRQ_ERR_NONE;
              end else begin
                rsp_d = '0;
                st_d = srq_pkg::ST_LIST;
                idx_d = '0;
                num_d = q_count;
              end
            end
            default: begin
              rsp_d = '0; // writes and preset give no answer
            end
          endcase
        end
      end
      srq_pkg::ST_LIST: begin
        rsp_d.valid = 1'b1;
        rsp_d.data = peek_code;
        rsp_d.last = list_last;
        idx_d = idx_q + 1'b1;
        if (list_last) begin
          st_d = srq_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = srq_pkg::ST_IDLE;
      end
    endcase
  end

  // error queue; overflow replaces the newest entry with the marker
  srq_err_fifo #(
    .W(ERR_W),
    .DEPTH(ERR_DEPTH)
  ) u_err_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .push(err_push),
    .push_data(err_code),
    .over_data(`SRQ_ERR_TOO_MANY),
    .pop(err_pop),
    .peek_idx(idx_q),
    .head_data(head_code),
    .peek_data(peek_code),
    .count(q_count),
    .empty(q_empty)
  );

  // status registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      oper_prev_q <= '0;
      ques_prev_q <= '0;
      oper_cond_q <= '0;
      ques_cond_q <= '0;
      oper_ev_q <= `SRQ_EVENT_RST;
      ques_ev_q <= `SRQ_EVENT_RST;
      oper_en_q <= `SRQ_MASK_RST;
      ques_en_q <= `SRQ_MASK_RST;
      stb_q <= `SRQ_STB_RST;
    end else begin
      oper_prev_q <= oper_live;
      ques_prev_q <= ques_live;
      oper_cond_q <= oper_cond_d;
      ques_cond_q <= ques_cond_d;
      oper_ev_q <= oper_ev_d;
      ques_ev_q <= ques_ev_d;
      oper_en_q <= oper_en_d;
      ques_en_q <= ques_en_d;
      stb_q <= stb_d;
    end
  end

  // sequencer and answer registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= srq_pkg::ST_IDLE;
      idx_q <= '0;
      num_q <= '0;
      rsp_q <= '0;
      ready_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      num_q <= num_d;
      rsp_q <= rsp_d;
      ready_q <= (st_d == srq_pkg::ST_IDLE);
      cnt_q <= q_count;
    end
  end

  assign cmd_ready = ready_q;
  assign rsp = rsp_q;
  assign status_byte = stb_q;
  assign err_count = cnt_q;

endmodule // srq_top

// ### dv/srq_top_assertions.sv
// concurrent checks on the status block ports
`timescale 1ns/10ps
module srq_top_assertions #(
  parameter int ERR_DEPTH = 15,
  parameter int ERR_W = 16,
  parameter int CW = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire srq_pkg::srq_cmd_type cmd,
  input wire logic cmd_ready,
  input wire logic err_push,
  input wire srq_pkg::srq_rsp_type rsp,
  input wire logic [7:0] status_byte,
  input wire logic [CW-1:0] err_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // decoded command kinds
  wire take = cmd.valid && cmd_ready;
  wire one_rd = take && (cmd.op inside {4'h2, 4'h3, 4'h4, 4'h6, 4'h7,
    4'h8, 4'ha, 4'hb});
  wire wr = take && (cmd.op inside {4'h1, 4'h5, 4'h9});
  wire pop = take && (cmd.op inside {4'ha, 4'hb});
  wire no_ev = !err_push && !pop;
  sequence list_mid;
    rsp.valid && !rsp.last;
  endsequence
  sequence quiet_pre;
    take && cmd.op == 4'h9 ##1 !cmd.valid;
  endsequence
  sequence calm;
    no_ev [*3];
  endsequence
  stb_spare_a: assert property (status_byte[6:4] == 3'h0 &&
    status_byte[2:0] == 3'h0) else $error("status spare bits set");
  read_answer_a: assert property (one_rd |=> rsp.valid && rsp.last)
    else $error("read gave no single answer");
  write_quiet_a: assert property (wr |=> !rsp.valid)
    else $error("write gave an answer");
  text_err_a: assert property (take && cmd.op == 4'ha |=> rsp.with_text)
    else $error("error read lacks text");
  text_code_a: assert property (take && cmd.op == 4'hb |=> !rsp.with_text)
    else $error("code read carries text");
  list_run_a: assert property (list_mid |=> rsp.valid)
    else $error("list words not back to back");
  list_hold_a: assert property (list_mid |-> !cmd_ready)
    else $error("ready during list");
  list_free_a: assert property (rsp.valid && rsp.last
    |-> cmd_ready) else $error("ready not back after list");
  count_cap_a: assert property (err_count <= ERR_DEPTH)
    else $error("queue count above depth");
  count_calm_a: assert property (calm |=> $stable(err_count))
    else $error("queue count moved without cause");
  preset_quiet_a: assert property (quiet_pre |=> status_byte == 8'h00)
    else $error("summary after preset");
endmodule // srq_top_assertions

bind srq_top srq_top_assertions #(.ERR_DEPTH(ERR_DEPTH), .ERR_W(ERR_W),
  .CW(CW)) u_chk (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd),
  .cmd_ready(cmd_ready), .err_push(err_push), .rsp(rsp),
  .status_byte(status_byte), .err_count(err_count));

// ### dv/srq_host.sv
// host side model issuing commands and gathering answer words
`timescale 1ns/10ps
module srq_host (
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire srq_pkg::srq_rsp_type rsp,
  output srq_pkg::srq_cmd_type cmd
);
  logic [15:0] got [$];
  logic txt;
  int stuck;
  initial begin
    cmd = '0;
    txt = 1'b0;
    stuck = 0;
  end
  // wait for ready, pulse one command, collect words up to the last
  task automatic ask(input srq_pkg::srq_op_type op, input logic [15:0] d,
    input bit rd);
    int n;
    got.delete();
    for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 40) stuck++;
    cmd = '{1'b1, op, d};
    @(posedge sys_clk);
    #1;
    cmd.valid = 1'b0;
    // the answer word stands from the taking edge for one cycle only
    for (n = 0; n < 24; n++) begin
      if (rsp.valid === 1'b1) begin
        got.push_back(rsp.data);
        txt = rsp.with_text;
        if (rsp.last === 1'b1) break;
      end
      @(posedge sys_clk);
      #1;
    end
    if (rd && n == 24) stuck++;
  endtask
endmodule // srq_host

// ### dv/testbench.sv
// self-checking bench for the status block
`timescale 1ns/10ps
`include "srq_cfg.svh"
module testbench;
  logic sys_clk;
  logic nrst;
  logic [4:0] fl;
  logic err_push;
  logic [15:0] err_code;
  srq_pkg::srq_cmd_type cmd;
  srq_pkg::srq_rsp_type rsp;
  logic cmd_ready;
  logic [7:0] status_byte;
  logic [3:0] err_count;
  int fail_count;
  int check_count;
  int i;
  srq_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd),
    .cmd_ready(cmd_ready), .cal_busy_flag(fl[0]),
    .trigger_wait_flag(fl[1]), .voltage_regulation_mode_flag(fl[2]),
    .current_limit_mode_flag(fl[3]), .over_temperature_flag(fl[4]),
    .err_push(err_push), .err_code(err_code), .rsp(rsp),
    .status_byte(status_byte), .err_count(err_count));
  srq_host u_host (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .rsp(rsp),
    .cmd(cmd));
  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one query whose single word is compared
  task automatic read1(input srq_pkg::srq_op_type op,
    input logic [15:0] exp, input string what);
    u_host.ask(op, 16'h0000, 1);
    check(what, u_host.got[0], exp);
  endtask
  task automatic close_out();
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    fl = 5'h00;
    err_push = 1'b0;
    err_code = 16'h0000;
    fail_count = 0;
    check_count = 0;
    step(16);
    nrst = 1'b1;
    step(2);
    check("status_byte", status_byte, 8'h00);
    u_host.ask(srq_pkg::OP_QUES_ENAB_WR, 16'hffff, 0);
    read1(srq_pkg::OP_QUES_ENAB_RD, `SRQ_QUES_IMPL, "qmask");
    u_host.ask(srq_pkg::OP_OPER_ENAB_WR, 16'hffff, 0);
    read1(srq_pkg::OP_OPER_ENAB_RD, `SRQ_OPER_IMPL, "omask");
    read1(srq_pkg::OP_QUES_EVEN_RD, 16'h0000, "q_idle");
    // overtemperature rises: live bit, latched bit, summary
    fl[4] = 1'b1;
    step(3);
    check("q_sum", status_byte, 8'h08);
    read1(srq_pkg::OP_QUES_COND_RD, 16'h0008, "q_live");
    read1(srq_pkg::OP_QUES_EVEN_RD, 16'h0008, "q_event");
    read1(srq_pkg::OP_QUES_EVEN_RD, 16'h0000, "q_again");
    check("q_clr", status_byte, 8'h00);
    fl[3:0] = 4'hf;
    step(3);
    check("o_sum", status_byte, 8'h80);
    read1(srq_pkg::OP_OPER_COND_RD, `SRQ_OPER_IMPL, "o_live");
    read1(srq_pkg::OP_OPER_EVEN_RD, `SRQ_OPER_IMPL, "o_event");
    read1(srq_pkg::OP_OPER_EVEN_RD, 16'h0000, "o_again");
    // a fresh event, then preset silences reporting
    fl[4] = 1'b0;
    step(2);
    fl[4] = 1'b1;
    step(3);
    u_host.ask(srq_pkg::OP_PRESET, 16'h0000, 0);
    check("p_sum", status_byte, 8'h00);
    read1(srq_pkg::OP_QUES_ENAB_RD, 16'h0000, "p_mask");
    read1(srq_pkg::OP_ERR_RD, `SRQ_ERR_NONE, "e_empty");
    check("e_text", u_host.txt, 1'b1);
    read1(srq_pkg::OP_ERR_ALL_RD, 16'h0000, "all_empty");
    // seventeen errors back to back overflow the queue
    for (i = 1; i <= 17; i++) begin
      err_code = 16'(i);
      err_push = 1'b1;
      step(1);
    end
    err_push = 1'b0;
    step(2);
    check("e_count", 16'(err_count), 16'h000f);
    u_host.ask(srq_pkg::OP_ERR_ALL_RD, 16'h0000, 1);
    check("all_len", 16'(u_host.got.size()), 16'h000f);
    for (i = 0; i < 15; i++) begin
      check("all_code", u_host.got[i],
        (i < 14) ? 16'(i + 1) : `SRQ_ERR_TOO_MANY);
    end
    // pops alternate full and code-only reads, oldest first
    for (i = 0; i < 15; i++) begin
      read1(i[0] ? srq_pkg::OP_ERR_CODE_RD : srq_pkg::OP_ERR_RD,
        (i < 14) ? 16'(i + 1) : `SRQ_ERR_TOO_MANY, "pop");
      check("pop_text", u_host.txt, !i[0]);
    end
    step(2);
    check("e_drain", 16'(err_count), 16'h0000);
    check("host_wait", 16'(u_host.stuck), 16'h0000);
    close_out();
  end
endmodule // testbench
